// ===== hdl/ptm_pkg.sv
package ptm_pkg;

	// ==========================================================
	// Sizes
	// ==========================================================
	localparam int TIMER_COUNT = 4;
	localparam int PAIR_COUNT  = 2;
	localparam int DATA_W      = 16;
	localparam int ADDR_W      = 4;
	localparam int PRIO_W      = 3;

	// ==========================================================
	// Register indices
	// ==========================================================
	localparam logic [3:0] CTRL_BASE   = 4'h0;
	localparam logic [3:0] PERIOD_BASE = 4'h4;
	localparam logic [3:0] COUNT_BASE  = 4'h8;
	localparam logic [3:0] IRQ_STATUS  = 4'hc;
	localparam logic [3:0] IRQ_MASK    = 4'hd;
	localparam logic [3:0] IRQ_PRIO    = 4'he;

	// ==========================================================
	// Control fields
	// ==========================================================
	localparam int CTRL_RUN        = 15;
	localparam int CTRL_IDLE_STOP  = 13;
	localparam int CTRL_GATE       = 6;
	localparam int CTRL_PRE_HI     = 5;
	localparam int CTRL_PRE_LO     = 4;
	localparam int CTRL_CHAIN      = 3;
	localparam int CTRL_SRC        = 1;
	localparam logic [15:0] CTRL_MASK_LOW  = 16'ha07a;
	localparam logic [15:0] CTRL_MASK_HIGH = 16'ha072;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [11:0] PRIO_RESET   = 12'h924;

	// ==========================================================
	// Prescaler terminal counts for ratios 1, 8, 64 and 256
	// ==========================================================
	localparam logic [7:0] PRE_LAST_0 = 8'h00;
	localparam logic [7:0] PRE_LAST_1 = 8'h07;
	localparam logic [7:0] PRE_LAST_2 = 8'h3f;
	localparam logic [7:0] PRE_LAST_3 = 8'hff;

	// Timers with a DMA trigger, as a mask with one bit per timer index.
	localparam logic [3:0] DMA_TIMERS = 4'h3;

endpackage

// ===== hdl/ptm_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ptm_pin_sync (
	// Clock and reset
	input  wire logic                             ref_clk_in,
	input  wire logic                             nrst_in,
	// Pins and synchronised levels
	input  wire logic [ptm_pkg::TIMER_COUNT-1:0]  pin_in,
	output var  logic [ptm_pkg::TIMER_COUNT-1:0]  sync_out
);

	logic [ptm_pkg::TIMER_COUNT-1:0] meta_q;
	logic [ptm_pkg::TIMER_COUNT-1:0] meta_d;
	logic [ptm_pkg::TIMER_COUNT-1:0] sync_d;

	always_comb begin
		meta_d = pin_in;
		sync_d = meta_q;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= meta_d;
			sync_out <= sync_d;
		end
	end

endmodule

`default_nettype wire

// ===== hdl/ptm_timer.sv
// What this block does
// - Each timer pair offers free timer, gated timer and synchronous counter modes.
// - Timer and gated modes count the instruction-cycle clock, here the block clock.
// - Counter mode counts rising edges of the timer's own external clock pin.
// - Source bit 1 and gate bit 6 select the mode; source set means counter.
// - Only timers 2 and 3 raise DMA requests; timers 4 and 5 never do.
// - Chaining bit 3 of the low timer joins the pair into one 32-bit timer.
// - When chained the high timer holds the upper word, the low timer the lower.
// - When chained only the low control governs; high keeps only stop-in-idle.
// - When chained the high timer's irq enable, flag and priority serve the pair.
// - Only timers 2 with 3 and 4 with 5 can be chained.
// - The chained timer offers the same three modes as a single timer.
// - The chained period is high period word over low period word.
// - The chained prescale ratio comes from the low timer's prescale field.
// - The 32-bit count reads as high count register over low count register.
// - Interrupt priority zero disables the source; one to seven enable it.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ptm_timer (
	// Clock and reset
	input  wire logic                             ref_clk_in,
	input  wire logic                             nrst_in,
	// Register port
	input  wire logic [ptm_pkg::ADDR_W-1:0]       addr_in,
	input  wire logic [ptm_pkg::DATA_W-1:0]       wr_data_in,
	input  wire logic                             wr_en_in,
	input  wire logic                             rd_en_in,
	output var  logic [ptm_pkg::DATA_W-1:0]       rd_data_out,
	// System state
	input  wire logic                             idle_in,
	// External clock and gate pins, one per timer
	input  wire logic [ptm_pkg::TIMER_COUNT-1:0]  ext_pin_in,
	// Requests
	output var  logic                             irq_out,
	output var  logic [1:0]                       dma_req_out
);

	// ==========================================================
	// Pin synchronisation and edges
	// ==========================================================
	logic [ptm_pkg::TIMER_COUNT-1:0] pin_lvl;
	logic [ptm_pkg::TIMER_COUNT-1:0] pin_prev_q;
	logic [ptm_pkg::TIMER_COUNT-1:0] pin_prev_d;
	logic [ptm_pkg::TIMER_COUNT-1:0] pin_rise;
	logic [ptm_pkg::TIMER_COUNT-1:0] pin_fall;

	ptm_pin_sync u_sync (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.pin_in     (ext_pin_in),
		.sync_out   (pin_lvl)
	);

	always_comb begin
		pin_prev_d = pin_lvl;
		pin_rise   = pin_lvl & ~pin_prev_q;
		pin_fall   = ~pin_lvl & pin_prev_q;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			pin_prev_q <= '0;
		end else begin
			pin_prev_q <= pin_prev_d;
		end
	end

	// ==========================================================
	// Register decode
	// ==========================================================
	logic [3:0] wr_ctrl;
	logic [3:0] wr_period;
	logic [3:0] wr_count;
	logic       wr_status;
	logic       wr_mask;
	logic       wr_prio;

	always_comb begin
		for (int t = 0; t < ptm_pkg::TIMER_COUNT; t++) begin
			wr_ctrl[t]   = wr_en_in && (addr_in == ptm_pkg::CTRL_BASE + 4'(t));
			wr_period[t] = wr_en_in && (addr_in == ptm_pkg::PERIOD_BASE + 4'(t));
			wr_count[t]  = wr_en_in && (addr_in == ptm_pkg::COUNT_BASE + 4'(t));
		end
		wr_status = wr_en_in && (addr_in == ptm_pkg::IRQ_STATUS);
		wr_mask   = wr_en_in && (addr_in == ptm_pkg::IRQ_MASK);
		wr_prio   = wr_en_in && (addr_in == ptm_pkg::IRQ_PRIO);
	end

	// ==========================================================
	// Control, period and interrupt registers
	// ==========================================================
	logic [15:0] ctrl_q   [ptm_pkg::TIMER_COUNT];
	logic [15:0] ctrl_d   [ptm_pkg::TIMER_COUNT];
	logic [15:0] period_q [ptm_pkg::TIMER_COUNT];
	logic [15:0] period_d [ptm_pkg::TIMER_COUNT];
	logic [3:0]  status_q;
	logic [3:0]  status_d;
	logic [3:0]  mask_q;
	logic [3:0]  mask_d;
	logic [11:0] prio_q;
	logic [11:0] prio_d;
	logic [3:0]  event_w;
	logic [3:0]  chained_low;
	logic [3:0]  irq_live;
	logic        irq_d;
	logic [1:0]  dma_d;

	always_comb begin
		for (int t = 0; t < ptm_pkg::TIMER_COUNT; t++) begin
			ctrl_d[t]   = ctrl_q[t];
			period_d[t] = period_q[t];
			if (wr_ctrl[t]) begin
				// The chaining bit exists only on the low timer of each pair.
				ctrl_d[t] = wr_data_in & (((t % 2) == 0) ? ptm_pkg::CTRL_MASK_LOW : ptm_pkg::CTRL_MASK_HIGH);
			end
			if (wr_period[t]) begin
				period_d[t] = wr_data_in;
			end
		end
		mask_d = wr_mask ? wr_data_in[3:0] : mask_q;
		prio_d = wr_prio ? wr_data_in[11:0] : prio_q;
		// A new event in the same cycle as a write-one clear keeps its flag.
		status_d = wr_status ? (status_q & ~wr_data_in[3:0]) : status_q;
		status_d = status_d | event_w;
		for (int t = 0; t < ptm_pkg::TIMER_COUNT; t++) begin
			chained_low[t] = ((t % 2) == 0) && ctrl_q[t][ptm_pkg::CTRL_CHAIN];
			irq_live[t]    = status_q[t] && mask_q[t] && !chained_low[t]
				&& (prio_q[t*ptm_pkg::PRIO_W +: ptm_pkg::PRIO_W] != 3'h0);
		end
		irq_d = |irq_live;
		dma_d = event_w[1:0] & ptm_pkg::DMA_TIMERS[1:0];
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			for (int t = 0; t < ptm_pkg::TIMER_COUNT; t++) begin
				ctrl_q[t]   <= ptm_pkg::CTRL_RESET;
				period_q[t] <= ptm_pkg::PERIOD_RESET;
			end
			status_q    <= '0;
			mask_q      <= '0;
			prio_q      <= ptm_pkg::PRIO_RESET;
			irq_out     <= 1'b0;
			dma_req_out <= '0;
		end else begin
			for (int t = 0; t < ptm_pkg::TIMER_COUNT; t++) begin
				ctrl_q[t]   <= ctrl_d[t];
				period_q[t] <= period_d[t];
			end
			status_q    <= status_d;
			mask_q      <= mask_d;
			prio_q      <= prio_d;
			irq_out     <= irq_d;
			dma_req_out <= dma_d;
		end
	end

	// ==========================================================
	// Timer pairs
	// ==========================================================
	logic [31:0] pair_count [ptm_pkg::PAIR_COUNT];

	for (genvar p = 0; p < ptm_pkg::PAIR_COUNT; p++) begin : g_pair
		localparam int LO = 2 * p;
		localparam int HI = 2 * p + 1;

		logic [7:0]  pre_q [2];
		logic [7:0]  pre_d [2];
		logic [15:0] cnt_q [2];
		logic [15:0] cnt_d [2];
		logic [1:0]  tick;
		logic [1:0]  gate_fall;
		logic [1:0]  ev;
		logic        chain;
		logic [15:0] cfg;
		logic        stop_idle;
		logic        src_tick;
		logic [7:0]  pre_last;
		logic [31:0] cnt32;
		logic [31:0] per32;

		always_comb begin
			chain     = ctrl_q[LO][ptm_pkg::CTRL_CHAIN];
			ev        = '0;
			tick      = '0;
			gate_fall = '0;
			cfg       = '0;
			stop_idle = 1'b0;
			src_tick  = 1'b0;
			pre_last  = ptm_pkg::PRE_LAST_0;
			for (int j = 0; j < 2; j++) begin
				pre_d[j] = pre_q[j];
				cnt_d[j] = cnt_q[j];
				// When chained the low control drives both halves.
				cfg       = (chain && j == 1) ? ctrl_q[LO] : ctrl_q[LO + j];
				stop_idle = chain ? ctrl_q[HI][ptm_pkg::CTRL_IDLE_STOP] : cfg[ptm_pkg::CTRL_IDLE_STOP];
				case (cfg[ptm_pkg::CTRL_PRE_HI:ptm_pkg::CTRL_PRE_LO])
					2'h0:    pre_last = ptm_pkg::PRE_LAST_0;
					2'h1:    pre_last = ptm_pkg::PRE_LAST_1;
					2'h2:    pre_last = ptm_pkg::PRE_LAST_2;
					2'h3:    pre_last = ptm_pkg::PRE_LAST_3;
					default: pre_last = ptm_pkg::PRE_LAST_0;
				endcase
				if (cfg[ptm_pkg::CTRL_SRC]) begin
					src_tick = pin_rise[LO + j];
				end else if (cfg[ptm_pkg::CTRL_GATE]) begin
					src_tick = pin_lvl[LO + j];
				end else begin
					src_tick = 1'b1;
				end
				if (!cfg[ptm_pkg::CTRL_RUN] || (idle_in && stop_idle) || (chain && j == 1)) begin
					src_tick = 1'b0;
				end
				gate_fall[j] = cfg[ptm_pkg::CTRL_RUN] && !(idle_in && stop_idle) && !(chain && j == 1)
					&& !cfg[ptm_pkg::CTRL_SRC] && cfg[ptm_pkg::CTRL_GATE] && pin_fall[LO + j];
				if (src_tick) begin
					if (pre_q[j] >= pre_last) begin
						pre_d[j] = '0;
						tick[j]  = 1'b1;
					end else begin
						pre_d[j] = pre_q[j] + 8'h01;
					end
				end
				if (chain && j == 1) begin
					pre_d[j] = '0;
				end
			end
			cnt32 = {cnt_q[1], cnt_q[0]};
			per32 = {period_q[HI], period_q[LO]};
			if (chain) begin
				if (tick[0]) begin
					if (cnt32 == per32) begin
						cnt_d[0] = '0;
						cnt_d[1] = '0;
						ev[1]    = 1'b1;
					end else begin
						{cnt_d[1], cnt_d[0]} = cnt32 + 32'h0000_0001;
					end
				end
				ev[1] = ev[1] | gate_fall[0];
			end else begin
				for (int j = 0; j < 2; j++) begin
					if (tick[j]) begin
						if (cnt_q[j] == period_q[LO + j]) begin
							cnt_d[j] = '0;
							ev[j]    = 1'b1;
						end else begin
							cnt_d[j] = cnt_q[j] + 16'h0001;
						end
					end
					ev[j] = ev[j] | gate_fall[j];
				end
			end
			if (wr_count[LO]) begin
				cnt_d[0] = wr_data_in;
			end
			if (wr_count[HI]) begin
				cnt_d[1] = wr_data_in;
			end
		end

		always_ff @(posedge ref_clk_in) begin
			if (!nrst_in) begin
				for (int j = 0; j < 2; j++) begin
					pre_q[j] <= '0;
					cnt_q[j] <= ptm_pkg::COUNT_RESET;
				end
			end else begin
				for (int j = 0; j < 2; j++) begin
					pre_q[j] <= pre_d[j];
					cnt_q[j] <= cnt_d[j];
				end
			end
		end

		assign event_w[LO]   = ev[0];
		assign event_w[HI]   = ev[1];
		assign pair_count[p] = {cnt_q[1], cnt_q[0]};
	end

	// ==========================================================
	// Read port, data one cycle after the strobe
	// ==========================================================
	logic [15:0] rd_d;

	always_comb begin
		rd_d = '0;
		if (rd_en_in) begin
			for (int t = 0; t < ptm_pkg::TIMER_COUNT; t++) begin
				if (addr_in == ptm_pkg::CTRL_BASE + 4'(t)) begin
					rd_d = ctrl_q[t];
				end
				if (addr_in == ptm_pkg::PERIOD_BASE + 4'(t)) begin
					rd_d = period_q[t];
				end
				if (addr_in == ptm_pkg::COUNT_BASE + 4'(t)) begin
					rd_d = pair_count[t / 2][(t % 2) * 16 +: 16];
				end
			end
			if (addr_in == ptm_pkg::IRQ_STATUS) begin
				rd_d = {12'h000, status_q};
			end
			if (addr_in == ptm_pkg::IRQ_MASK) begin
				rd_d = {12'h000, mask_q};
			end
			if (addr_in == ptm_pkg::IRQ_PRIO) begin
				rd_d = {4'h0, prio_q};
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			rd_data_out <= '0;
		end else begin
			rd_data_out <= rd_d;
		end
	end

endmodule

`default_nettype wire

// ===== tb/ptm_props.sv
`timescale 1ns/1ps
`default_nettype none

module ptm_props (
	// Clock and reset
	input wire logic        ref_clk_in,
	input wire logic        nrst_in,
	// Register port
	input wire logic [3:0]  addr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic        wr_en_in,
	input wire logic        rd_en_in,
	input wire logic [15:0] rd_data_out,
	// Requests
	input wire logic        irq_out,
	input wire logic [1:0]  dma_req_out
);
	// ==========================================================
	// Shadow copies of the control, period, mask and priority registers
	// ==========================================================
	logic [15:0] ctl_q [4];
	logic [15:0] per_q [4];
	logic [3:0]  msk_q;
	logic [11:0] pri_q;

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			ctl_q <= '{default: ptm_pkg::CTRL_RESET};
			per_q <= '{default: ptm_pkg::PERIOD_RESET};
			msk_q <= 4'h0;
			pri_q <= ptm_pkg::PRIO_RESET;
		end else if (wr_en_in) begin
			if (addr_in[3:2] == 2'h0)
				ctl_q[addr_in[1:0]] <= wr_data_in & (addr_in[0] ? ptm_pkg::CTRL_MASK_HIGH : ptm_pkg::CTRL_MASK_LOW);
			if (addr_in[3:2] == 2'h1)
				per_q[addr_in[1:0]] <= wr_data_in;
			if (addr_in == ptm_pkg::IRQ_MASK)
				msk_q <= wr_data_in[3:0];
			if (addr_in == ptm_pkg::IRQ_PRIO)
				pri_q <= wr_data_in[11:0];
		end
	end

	// ==========================================================
	// Properties
	// ==========================================================
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	a_read_idle_zero: assert property (
		!rd_en_in |=> rd_data_out == 16'h0) else $error("read data outside a read");
	a_unmapped_zero: assert property (
		rd_en_in && addr_in == 4'hf |=> rd_data_out == 16'h0) else $error("unmapped read not zero");
	a_reset_quiet: assert property (
		$rose(nrst_in) |-> !irq_out && dma_req_out == 2'h0 && rd_data_out == 16'h0) else $error("busy in reset");
	a_ctrl_readback: assert property (
		rd_en_in && addr_in[3:2] == 2'h0 |=> rd_data_out == ctl_q[$past(addr_in[1:0])])
		else $error("control readback wrong");
	a_period_readback: assert property (
		rd_en_in && addr_in[3:2] == 2'h1 |=> rd_data_out == per_q[$past(addr_in[1:0])])
		else $error("period readback wrong");
	a_mask_readback: assert property (
		rd_en_in && addr_in == 4'hd |=> rd_data_out == {12'h0, msk_q}) else $error("mask readback wrong");
	a_prio_readback: assert property (
		rd_en_in && addr_in == 4'he |=> rd_data_out == {4'h0, pri_q}) else $error("priority readback wrong");
	a_mask_kills_irq: assert property (
		wr_en_in && addr_in == 4'hd && wr_data_in == 16'h0 |-> ##2 !irq_out) else $error("masked irq high");
	a_prio_kills_irq: assert property (
		wr_en_in && addr_in == 4'he && wr_data_in == 16'h0 |-> ##2 !irq_out) else $error("irq at priority 0");
	a_irq_needs_mask: assert property (
		irq_out |-> $past(msk_q) != 4'h0) else $error("irq with all sources masked");
endmodule

bind ptm_timer ptm_props u_props (
	.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
	.wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
	.rd_data_out(rd_data_out), .irq_out(irq_out), .dma_req_out(dma_req_out)
);

`default_nettype wire

// ===== tb/ptm_ext_src.sv
`timescale 1ns/1ps
`default_nettype none

module ptm_ext_src (
	// Clock
	input  wire logic       ref_clk_in,
	// Frame controls
	input  wire logic [3:0] run_in,
	input  wire logic [3:0] hold_in,
	input  wire logic       slow_in,
	// Pins
	output var  logic [3:0] pin_out
);
	logic [1:0] cnt_q;
	logic       tog_q;

	// The count clock stands low outside frames, like a pulled-down pin.
	always_ff @(posedge ref_clk_in) begin
		if (run_in == 4'h0) begin
			cnt_q <= 2'h0;
			tog_q <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			if (cnt_q == 2'h3 || (!slow_in && cnt_q[0]))
				tog_q <= ~tog_q;
		end
	end

	assign pin_out = hold_in | (run_in & {4{tog_q}});
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdat = 16'h0;
	logic        we = 1'b0;
	logic        re = 1'b0;
	logic [3:0]  run = 4'h0;
	logic [3:0]  hold = 4'h0;
	logic        slow = 1'b0;
	logic        idle = 1'b0;
	logic [3:0]  pins;
	logic [15:0] rdat;
	logic        irq;
	logic [1:0]  dma;
	logic [15:0] v;
	int          dma0_n = 0;
	int          dma1_n = 0;
	int          n_fail = 0;
	int          num_checks = 0;

	ptm_timer uut (.ref_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wr_data_in(wdat),
		.wr_en_in(we), .rd_en_in(re), .rd_data_out(rdat), .idle_in(idle),
		.ext_pin_in(pins), .irq_out(irq), .dma_req_out(dma));
	ptm_ext_src u_src (.ref_clk_in(clk), .run_in(run), .hold_in(hold), .slow_in(slow), .pin_out(pins));

	initial begin
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (dma[0]) dma0_n++;
		if (dma[1]) dma1_n++;
	end

	// ==========================================================
	// Bus and check tasks
	// ==========================================================
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic in_range(input logic [15:0] lo, input logic [15:0] hi);
		chk({15'h0, v >= lo && v <= hi}, 16'h1);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 v = rdat;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_reset();
		for (int i = 0; i < 4; i++) begin
			rd(4'(i));
			chk(v, 16'h0000);
			rd(4'(4 + i));
			chk(v, 16'hffff);
			rd(4'(8 + i));
			chk(v, 16'h0000);
			wr(4'(i), 16'h7fff);
			rd(4'(i));
			chk(v, i[0] ? 16'h2072 : 16'h207a);
			wr(4'(i), 16'h0000);
		end
		rd(4'he);
		chk(v, 16'h0924);
		wr(4'hf, 16'h1234);
		rd(4'hf);
		chk(v, 16'h0000);
		$display("reset test done");
	endtask

	task automatic t_period();
		int c0;
		c0 = dma0_n + dma1_n;
		wr(4'hc, 16'h000f);
		wr(4'h2, 16'h0000);
		wr(4'h6, 16'h0003);
		wr(4'h2, 16'h8000);
		repeat (20) @(posedge clk);
		wr(4'h2, 16'h0000);
		rd(4'ha);
		in_range(16'h0, 16'h3);
		rd(4'hc);
		chk(v & 16'h4, 16'h4);
		chk(16'(dma0_n + dma1_n - c0), 16'h0);
		wr(4'ha, 16'h0000);
		wr(4'h2, 16'h0010);
		wr(4'h6, 16'hffff);
		wr(4'h2, 16'h8010);
		repeat (80) @(posedge clk);
		wr(4'h2, 16'h0010);
		rd(4'ha);
		in_range(16'h9, 16'hb);
		// The prescaler keeps its phase across stops, so the longer ratios allow one tick of slack.
		for (int r = 2; r < 4; r++) begin
			wr(4'ha, 16'h0000);
			wr(4'h2, (r == 2) ? 16'h8020 : 16'h8030);
			repeat ((r == 2) ? 200 : 600) @(posedge clk);
			wr(4'h2, 16'h0000);
			rd(4'ha);
			in_range((r == 2) ? 16'h2 : 16'h1, (r == 2) ? 16'h4 : 16'h3);
		end
		$display("period test done");
	endtask

	task automatic t_chain();
		int c0;
		int c1;
		wr(4'hc, 16'h000f);
		wr(4'hd, 16'h0002);
		wr(4'h0, 16'h0008);
		wr(4'h5, 16'h0001);
		wr(4'h4, 16'hffff);
		wr(4'h8, 16'hfff0);
		wr(4'h9, 16'h0000);
		wr(4'h0, 16'h8008);
		repeat (40) @(posedge clk);
		wr(4'h0, 16'h0008);
		rd(4'h9);
		chk(v, 16'h0001);
		rd(4'h8);
		in_range(16'h0010, 16'h0028);
		rd(4'hc);
		chk(v, 16'h0000);
		wr(4'h5, 16'h0000);
		wr(4'h4, 16'h0005);
		// Both count words must restart, or the 32-bit count never meets the period.
		wr(4'h8, 16'h0000);
		wr(4'h9, 16'h0000);
		c0 = dma0_n;
		c1 = dma1_n;
		wr(4'h0, 16'h8008);
		repeat (30) @(posedge clk);
		wr(4'h0, 16'h0008);
		settle(4);
		rd(4'hc);
		chk(v, 16'h0002);
		chk({15'h0, irq}, 16'h1);
		chk(16'(dma0_n - c0), 16'h0);
		chk({15'h0, dma1_n != c1}, 16'h1);
		wr(4'hc, 16'h0002);
		settle(3);
		chk({15'h0, irq}, 16'h0);
		wr(4'h0, 16'h0000);
		$display("chain test done");
	endtask

	task automatic t_counter();
		for (int s = 0; s < 2; s++) begin
			wr(4'ha, 16'h0000);
			wr(4'h2, 16'h8002);
			slow <= s[0];
			run <= 4'h4;
			repeat (40) @(posedge clk);
			run <= 4'h0;
			repeat (8) @(posedge clk);
			wr(4'h2, 16'h0000);
			rd(4'ha);
			in_range(s ? 16'h4 : 16'h9, s ? 16'h5 : 16'ha);
		end
		$display("counter test done");
	endtask

	task automatic t_gated();
		wr(4'hc, 16'h000f);
		wr(4'hd, 16'h0008);
		wr(4'hb, 16'h0000);
		wr(4'h3, 16'h8040);
		repeat (10) @(posedge clk);
		hold <= 4'h8;
		repeat (20) @(posedge clk);
		hold <= 4'h0;
		repeat (6) @(posedge clk);
		wr(4'h3, 16'h0040);
		rd(4'hb);
		in_range(16'd19, 16'd21);
		rd(4'hc);
		chk(v, 16'h0008);
		chk({15'h0, irq}, 16'h1);
		wr(4'he, 16'h0000);
		settle(3);
		chk({15'h0, irq}, 16'h0);
		wr(4'he, 16'h0924);
		settle(3);
		chk({15'h0, irq}, 16'h1);
		wr(4'hd, 16'h0000);
		settle(3);
		chk({15'h0, irq}, 16'h0);
		$display("gated test done");
	endtask

	task automatic t_idle();
		wr(4'h8, 16'h0000);
		wr(4'h9, 16'h0000);
		wr(4'h5, 16'hffff);
		wr(4'h4, 16'hffff);
		wr(4'h1, 16'h2000);
		idle <= 1'b1;
		wr(4'h0, 16'h8008);
		repeat (20) @(posedge clk);
		wr(4'h0, 16'h0008);
		rd(4'h8);
		chk(v, 16'h0000);
		// The low timer's own stop-in-idle bit must not freeze a chained pair.
		wr(4'h1, 16'h0000);
		wr(4'h0, 16'ha008);
		repeat (20) @(posedge clk);
		wr(4'h0, 16'h2008);
		rd(4'h8);
		chk(v, 16'h0016);
		rd(4'h9);
		chk(v, 16'h0000);
		wr(4'h0, 16'h0000);
		wr(4'ha, 16'h0000);
		wr(4'h2, 16'ha000);
		repeat (10) @(posedge clk);
		wr(4'h2, 16'h0000);
		rd(4'ha);
		chk(v, 16'h0000);
		idle <= 1'b0;
		$display("idle test done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_period();
		t_chain();
		t_counter();
		t_gated();
		t_idle();
		report_and_stop();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule

`default_nettype wire
